/* logic/mcu_alu_pkg.sv */
// Shared constants, types and decode helpers of the 8-bit ALU
package mcu_alu_pkg;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WAIT   = 2'b01,
        ST_MULDIV = 2'b10
    } alu_state_t;

    // Opcodes handled as single cases
    localparam logic [7:0] OPC_INC_A = 8'h04;
    localparam logic [7:0] OPC_DEC_A = 8'h14;
    localparam logic [7:0] OPC_INC_DATA_POINTER_REG = 8'hA3;
    localparam logic [7:0] OPC_MUL = 8'hA4;
    localparam logic [7:0] OPC_DIV = 8'h84;
    localparam logic [7:0] OPC_DA = 8'hD4;
    localparam logic [7:0] OPC_CLR = 8'hE4;
    localparam logic [7:0] OPC_CPL = 8'hF4;
    localparam logic [7:0] OPC_RL = 8'h23;
    localparam logic [7:0] OPC_RLC = 8'h33;
    localparam logic [7:0] OPC_RR = 8'h03;
    localparam logic [7:0] OPC_RRC = 8'h13;
    localparam logic [7:0] OPC_SWAP = 8'hC4;

    // High nibble of each opcode group
    localparam logic [3:0] GRP_INC = 4'h0;
    localparam logic [3:0] GRP_DEC = 4'h1;
    localparam logic [3:0] GRP_ADD = 4'h2;
    localparam logic [3:0] GRP_ADD_WITH_CARRY = 4'h3;
    localparam logic [3:0] GRP_ORL = 4'h4;
    localparam logic [3:0] GRP_ANL = 4'h5;
    localparam logic [3:0] GRP_XRL = 4'h6;
    localparam logic [3:0] GRP_SUBTRACT_WITH_BORROW = 4'h9;

    // Low nibble boundaries of the addressing forms
    localparam logic [3:0] LO_TO_LOC = 4'h2;
    localparam logic [3:0] LO_IMM_TO_LOC = 4'h3;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIRECT = 4'h5;
    localparam logic [3:0] LO_REG = 4'h8;

    // Flag positions in the status byte
    localparam int PSW_CY = 7;
    localparam int PSW_AC = 6;
    localparam int PSW_OV = 2;
    localparam int PSW_P = 0;

    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] B_RESET = 8'h00;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [15:0] WORD_ONE = 16'h0001;

    // Decimal adjust thresholds
    localparam logic [3:0] DA_DIGIT_MAX = 4'h9;
    localparam logic [8:0] DA_ADJ_LO = 9'h006;
    localparam logic [8:0] DA_ADJ_HI = 9'h060;

    // Cycle counts, one core clock each
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR = 3'h4;
    localparam logic [2:0] CYC_MULDIV = 3'h5;
    localparam logic [1:0] MULDIV_LAST_STEP = 2'h3;

    function automatic logic accGroup(input logic [3:0] hi);
        return hi == GRP_ADD || hi == GRP_ADD_WITH_CARRY || hi == GRP_SUBTRACT_WITH_BORROW ||
            hi == GRP_ORL || hi == GRP_ANL || hi == GRP_XRL;
    endfunction

    function automatic logic logicGroup(input logic [3:0] hi);
        return hi == GRP_ORL || hi == GRP_ANL || hi == GRP_XRL;
    endfunction

    function automatic logic [2:0] aluCycles(input logic [7:0] code);
        logic [3:0] hi;
        logic [3:0] lo;
        logic [2:0] cyc;
        hi = code[7:4];
        lo = code[3:0];
        cyc = CYC_ONE;
        if (code == OPC_MUL || code == OPC_DIV) begin
            cyc = CYC_MULDIV;
        end else if (accGroup(hi) && lo >= LO_REG) begin
            cyc = CYC_ONE;
        end else if (accGroup(hi) && lo >= LO_IMM) begin
            cyc = CYC_TWO;
        end else if (logicGroup(hi) && lo == LO_TO_LOC) begin
            cyc = CYC_THREE;
        end else if (logicGroup(hi) && lo == LO_IMM_TO_LOC) begin
            cyc = CYC_FOUR;
        end else if ((hi == GRP_INC || hi == GRP_DEC) && lo >= LO_REG) begin
            cyc = CYC_TWO;
        end else if ((hi == GRP_INC || hi == GRP_DEC) && lo >= LO_DIRECT
            && lo < LO_REG) begin
            cyc = CYC_THREE;
        end
        return cyc;
    endfunction

endpackage

/* logic/mcu_muldiv_unit.sv */
// Iterative 8x8 multiplier and 8/8 divider, two bits per clock
`timescale 1ns/1ps
module mcu_muldiv_unit (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic isDivide,
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    output logic lastStep,
    output logic [7:0] resHi,
    output logic [7:0] resLo
);

    logic busy_ff, nxt_busy;
    logic div_ff, nxt_div;
    logic [1:0] step_ff, nxt_step;
    logic [17:0] work_ff, nxt_work;
    logic [7:0] dvs_ff, nxt_dvs;

    always_comb begin
        logic [9:0] part;
        logic [17:0] sum;
        logic [8:0] rem;
        logic [7:0] quo;
        part = 10'h000;
        sum = 18'h0_0000;
        rem = work_ff[16:8];
        quo = work_ff[7:0];
        nxt_busy = busy_ff;
        nxt_div = div_ff;
        nxt_step = step_ff;
        nxt_work = work_ff;
        nxt_dvs = dvs_ff;
        if (load) begin
            nxt_busy = 1'b1;
            nxt_div = isDivide;
            nxt_step = 2'h0;
            nxt_work = {10'h000, opA};
            nxt_dvs = opB;
        end else if (busy_ff) begin
            if (div_ff) begin
                // Restoring division, remainder above quotient
                for (int i = 0; i < 2; i++) begin
                    rem = {rem[7:0], quo[7]};
                    quo = {quo[6:0], 1'b0};
                    if (rem >= {1'b0, dvs_ff}) begin
                        rem = rem - {1'b0, dvs_ff};
                        quo[0] = 1'b1;
                    end
                end
                nxt_work = {1'b0, rem, quo};
            end else begin
                // Shift-add on two multiplier bits
                part = ({2'b00, dvs_ff} & {10{work_ff[0]}}) +
                    ({1'b0, dvs_ff, 1'b0} & {10{work_ff[1]}});
                sum = work_ff + {part, 8'h00};
                nxt_work = {2'b00, sum[17:2]};
            end
            nxt_step = step_ff + 2'h1;
            if (step_ff == mcu_alu_pkg::MULDIV_LAST_STEP) begin
                nxt_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
            div_ff <= 1'b0;
            step_ff <= 2'h0;
            work_ff <= 18'h0_0000;
            dvs_ff <= 8'h00;
        end else begin
            busy_ff <= nxt_busy;
            div_ff <= nxt_div;
            step_ff <= nxt_step;
            work_ff <= nxt_work;
            dvs_ff <= nxt_dvs;
        end
    end

    assign lastStep = busy_ff && step_ff == mcu_alu_pkg::MULDIV_LAST_STEP;
    assign resHi = nxt_work[15:8];
    assign resLo = nxt_work[7:0];

endmodule

/* logic/mcu_arithmetic_logic_unit.sv */
// 8-bit ALU of the core with operand registers and status flags
//
// How it works
// - One machine cycle is one core clock, so counts are clock periods.
// - Operands are unsigned; add, add with carry, subtract with borrow.
// - Rotates, swap, clear, complement, decimal adjust touch only acc, plus carry for RLC, RRC and decimal adjust.
// - Operands come from acc, b or outside; results go to acc, b or out.
// - Carry, overflow and parity live in the status flag register.
// - Opcodes keep the legacy encoding and function; only timing moves.
// - Add: 0x28-0x2F one cycle, 0x25/0x26-0x27/0x24 two cycles.
// - Add with carry: 0x38-0x3F one cycle, 0x34-0x37 two cycles.
// - Subtract with borrow: 0x98-0x9F one cycle, 0x94-0x97 two cycles.
// - Increment acc 0x04, pointer 0xA3, decrement acc 0x14: one cycle.
// - Increment direct/indirect three cycles, working register two.
// - Decrement direct/indirect three cycles, working register two.
// - Multiply 0xA4 and divide 0x84 complete in five cycles.
// - Decimal adjust 0xD4 completes in one cycle.
`timescale 1ns/1ps
module mcu_arithmetic_logic_unit (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic opStart,
    input wire logic [7:0] opCode,
    input wire logic [7:0] operandIn,
    input wire logic [7:0] immIn,
    input wire logic [15:0] dptrIn,
    input wire logic accWrEn,
    input wire logic bWrEn,
    input wire logic pswWrEn,
    input wire logic [7:0] sfrWrData,
    output logic opReady,
    output logic opDone,
    output logic [7:0] accOut,
    output logic [7:0] bOut,
    output logic [7:0] pswOut,
    output logic [7:0] resultOut,
    output logic resultValid,
    output logic [15:0] dptrOut,
    output logic dptrValid
);

    ////////////////////////////////////////////////////////////////////
    mcu_alu_pkg::alu_state_t state_ff, nxt_state;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [7:0] code_ff, nxt_code;
    logic [7:0] opnd_ff, nxt_opnd;
    logic [7:0] imm_ff, nxt_imm;
    logic [7:0] acc_ff, nxt_acc;
    logic [7:0] b_ff, nxt_b;
    logic [7:0] psw_ff, nxt_psw;
    logic [7:0] res_ff, nxt_res;
    logic resV_ff, nxt_resV;
    logic [15:0] data_pointer_reg_ff, nxt_data_pointer_reg;
    logic dptrV_ff, nxt_dptrV;
    logic take, commit, mdLoad, mdLast;
    logic [2:0] cyc;
    logic [7:0] curCode, curOpnd, curImm;
    logic [7:0] mdHi, mdLo;

    function automatic logic [7:0] logicOp(input logic [3:0] hi,
        input logic [7:0] x, input logic [7:0] y);
        logic [7:0] r;
        r = x ^ y;
        if (hi == mcu_alu_pkg::GRP_ANL) begin
            r = x & y;
        end else if (hi == mcu_alu_pkg::GRP_ORL) begin
            r = x | y;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Sequencing: ops of N cycles commit at the Nth edge after take
    assign take = state_ff == mcu_alu_pkg::ST_IDLE && opStart;
    assign cyc = mcu_alu_pkg::aluCycles(opCode);
    assign mdLoad = take && (opCode == mcu_alu_pkg::OPC_MUL ||
        opCode == mcu_alu_pkg::OPC_DIV);
    assign commit = (take && cyc == mcu_alu_pkg::CYC_ONE) ||
        (state_ff == mcu_alu_pkg::ST_WAIT && cnt_ff == 3'h1) ||
        (state_ff == mcu_alu_pkg::ST_MULDIV && mdLast);
    assign curCode = take ? opCode : code_ff;
    assign curOpnd = take ? operandIn : opnd_ff;
    assign curImm = take ? immIn : imm_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_code = code_ff;
        nxt_opnd = opnd_ff;
        nxt_imm = imm_ff;
        case (state_ff)
            mcu_alu_pkg::ST_IDLE: begin
                if (opStart) begin
                    nxt_code = opCode;
                    nxt_opnd = operandIn;
                    nxt_imm = immIn;
                    nxt_cnt = cyc - 3'h1;
                    if (mdLoad) begin
                        nxt_state = mcu_alu_pkg::ST_MULDIV;
                    end else if (cyc != mcu_alu_pkg::CYC_ONE) begin
                        nxt_state = mcu_alu_pkg::ST_WAIT;
                    end
                end
            end
            mcu_alu_pkg::ST_WAIT: begin
                nxt_cnt = cnt_ff - 3'h1;
                if (cnt_ff == 3'h1) begin
                    nxt_state = mcu_alu_pkg::ST_IDLE;
                end
            end
            mcu_alu_pkg::ST_MULDIV: begin
                if (mdLast) begin
                    nxt_state = mcu_alu_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = mcu_alu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= mcu_alu_pkg::ST_IDLE;
            cnt_ff <= 3'h0;
            code_ff <= 8'h00;
            opnd_ff <= 8'h00;
            imm_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            code_ff <= nxt_code;
            opnd_ff <= nxt_opnd;
            imm_ff <= nxt_imm;
        end
    end

    mcu_muldiv_unit u_muldiv (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(mdLoad),
        .isDivide(opCode == mcu_alu_pkg::OPC_DIV),
        .opA(acc_ff),
        .opB(b_ff),
        .lastStep(mdLast),
        .resHi(mdHi),
        .resLo(mdLo)
    );

    ////////////////////////////////////////////////////////////////////
    // Datapath and flags
    always_comb begin
        logic [3:0] hi;
        logic [3:0] lo;
        logic cin;
        logic [8:0] full;
        logic [4:0] half;
        logic [8:0] da;
        hi = curCode[7:4];
        lo = curCode[3:0];
        cin = psw_ff[mcu_alu_pkg::PSW_CY];
        full = 9'h000;
        half = 5'h00;
        da = {1'b0, acc_ff};
        nxt_acc = acc_ff;
        nxt_b = b_ff;
        nxt_psw = psw_ff;
        nxt_res = res_ff;
        nxt_resV = 1'b0;
        nxt_data_pointer_reg = data_pointer_reg_ff;
        nxt_dptrV = 1'b0;
        if (accWrEn) begin
            nxt_acc = sfrWrData;
        end
        if (bWrEn) begin
            nxt_b = sfrWrData;
        end
        if (pswWrEn) begin
            nxt_psw = sfrWrData;
        end
        if (commit) begin
            if (curCode == mcu_alu_pkg::OPC_MUL ||
                curCode == mcu_alu_pkg::OPC_DIV) begin
                nxt_acc = mdLo;
                nxt_b = mdHi;
                nxt_psw[mcu_alu_pkg::PSW_CY] = 1'b0;
                nxt_psw[mcu_alu_pkg::PSW_OV] =
                    (curCode == mcu_alu_pkg::OPC_DIV) ?
                    (b_ff == mcu_alu_pkg::BYTE_ZERO) :
                    (mdHi != mcu_alu_pkg::BYTE_ZERO);
            end else if ((hi == mcu_alu_pkg::GRP_ADD ||
                hi == mcu_alu_pkg::GRP_ADD_WITH_CARRY) &&
                lo >= mcu_alu_pkg::LO_IMM) begin
                if (hi == mcu_alu_pkg::GRP_ADD) begin
                    cin = 1'b0;
                end
                full = {1'b0, acc_ff} + {1'b0, curOpnd} +
                    {8'h00, cin};
                half = {1'b0, acc_ff[3:0]} + {1'b0, curOpnd[3:0]} +
                    {4'h0, cin};
                nxt_acc = full[7:0];
                nxt_psw[mcu_alu_pkg::PSW_CY] = full[8];
                nxt_psw[mcu_alu_pkg::PSW_AC] = half[4];
                nxt_psw[mcu_alu_pkg::PSW_OV] = (acc_ff[7] == curOpnd[7])
                    && (full[7] != acc_ff[7]);
            end else if (hi == mcu_alu_pkg::GRP_SUBTRACT_WITH_BORROW &&
                lo >= mcu_alu_pkg::LO_IMM) begin
                full = {1'b0, acc_ff} - {1'b0, curOpnd} -
                    {8'h00, cin};
                half = {1'b0, acc_ff[3:0]} - {1'b0, curOpnd[3:0]} -
                    {4'h0, cin};
                nxt_acc = full[7:0];
                nxt_psw[mcu_alu_pkg::PSW_CY] = full[8];
                nxt_psw[mcu_alu_pkg::PSW_AC] = half[4];
                nxt_psw[mcu_alu_pkg::PSW_OV] = (acc_ff[7] != curOpnd[7])
                    && (full[7] != acc_ff[7]);
            end else if (mcu_alu_pkg::logicGroup(hi) &&
                lo >= mcu_alu_pkg::LO_IMM) begin
                nxt_acc = logicOp(hi, acc_ff, curOpnd);
            end else if (mcu_alu_pkg::logicGroup(hi) &&
                lo == mcu_alu_pkg::LO_TO_LOC) begin
                nxt_res = logicOp(hi, curOpnd, acc_ff);
                nxt_resV = 1'b1;
            end else if (mcu_alu_pkg::logicGroup(hi) &&
                lo == mcu_alu_pkg::LO_IMM_TO_LOC) begin
                nxt_res = logicOp(hi, curOpnd, curImm);
                nxt_resV = 1'b1;
            end else if (curCode == mcu_alu_pkg::OPC_INC_A) begin
                nxt_acc = acc_ff + mcu_alu_pkg::BYTE_ONE;
            end else if (curCode == mcu_alu_pkg::OPC_DEC_A) begin
                nxt_acc = acc_ff - mcu_alu_pkg::BYTE_ONE;
            end else if ((hi == mcu_alu_pkg::GRP_INC ||
                hi == mcu_alu_pkg::GRP_DEC) &&
                lo >= mcu_alu_pkg::LO_DIRECT) begin
                nxt_res = (hi == mcu_alu_pkg::GRP_INC) ?
                    curOpnd + mcu_alu_pkg::BYTE_ONE :
                    curOpnd - mcu_alu_pkg::BYTE_ONE;
                nxt_resV = 1'b1;
            end else begin
                case (curCode)
                    mcu_alu_pkg::OPC_INC_DATA_POINTER_REG: begin
                        nxt_data_pointer_reg = dptrIn + mcu_alu_pkg::WORD_ONE;
                        nxt_dptrV = 1'b1;
                    end
                    mcu_alu_pkg::OPC_CLR: begin
                        nxt_acc = mcu_alu_pkg::BYTE_ZERO;
                    end
                    mcu_alu_pkg::OPC_CPL: begin
                        nxt_acc = ~acc_ff;
                    end
                    mcu_alu_pkg::OPC_RL: begin
                        nxt_acc = {acc_ff[6:0], acc_ff[7]};
                    end
                    mcu_alu_pkg::OPC_RR: begin
                        nxt_acc = {acc_ff[0], acc_ff[7:1]};
                    end
                    mcu_alu_pkg::OPC_RLC: begin
                        nxt_acc = {acc_ff[6:0], cin};
                        nxt_psw[mcu_alu_pkg::PSW_CY] = acc_ff[7];
                    end
                    mcu_alu_pkg::OPC_RRC: begin
                        nxt_acc = {cin, acc_ff[7:1]};
                        nxt_psw[mcu_alu_pkg::PSW_CY] = acc_ff[0];
                    end
                    mcu_alu_pkg::OPC_SWAP: begin
                        nxt_acc = {acc_ff[3:0], acc_ff[7:4]};
                    end
                    mcu_alu_pkg::OPC_DA: begin
                        // Carry is only ever set here, never cleared
                        if (acc_ff[3:0] > mcu_alu_pkg::DA_DIGIT_MAX ||
                            psw_ff[mcu_alu_pkg::PSW_AC]) begin
                            da = da + mcu_alu_pkg::DA_ADJ_LO;
                        end
                        if (da[8] || cin ||
                            da[7:4] > mcu_alu_pkg::DA_DIGIT_MAX) begin
                            da = da + mcu_alu_pkg::DA_ADJ_HI;
                        end
                        nxt_acc = da[7:0];
                        nxt_psw[mcu_alu_pkg::PSW_CY] = cin | da[8];
                    end
                    default: begin
                        nxt_acc = acc_ff;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_ff <= mcu_alu_pkg::ACC_RESET;
            b_ff <= mcu_alu_pkg::B_RESET;
            psw_ff <= mcu_alu_pkg::PSW_RESET;
            res_ff <= 8'h00;
            resV_ff <= 1'b0;
            data_pointer_reg_ff <= 16'h0000;
            dptrV_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            b_ff <= nxt_b;
            psw_ff <= nxt_psw;
            res_ff <= nxt_res;
            resV_ff <= nxt_resV;
            data_pointer_reg_ff <= nxt_data_pointer_reg;
            dptrV_ff <= nxt_dptrV;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign opReady = state_ff == mcu_alu_pkg::ST_IDLE;
    assign opDone = commit;
    assign accOut = acc_ff;
    assign bOut = b_ff;
    // Parity always tracks the accumulator
    assign pswOut = {psw_ff[7:1], ^acc_ff};
    assign resultOut = res_ff;
    assign resultValid = resV_ff;
    assign dptrOut = data_pointer_reg_ff;
    assign dptrValid = dptrV_ff;

endmodule

/* sim/mcu_alu_assertions.sv */
// Port-level timing and flag checks for the ALU
`timescale 1ns/1ps
module mcu_alu_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic opStart,
    input wire logic [7:0] opCode,
    input wire logic [7:0] operandIn,
    input wire logic [7:0] immIn,
    input wire logic [15:0] dptrIn,
    input wire logic accWrEn,
    input wire logic bWrEn,
    input wire logic pswWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic opReady,
    input wire logic opDone,
    input wire logic [7:0] accOut,
    input wire logic [7:0] bOut,
    input wire logic [7:0] pswOut,
    input wire logic [7:0] resultOut,
    input wire logic resultValid,
    input wire logic [15:0] dptrOut,
    input wire logic dptrValid
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic take;
    assign take = opStart && opReady;
    ////////////////////////////////////////////////////////////////////
    property p_inc_acc;
        take && opCode == 8'h04 |-> opDone;
    endproperty
    a_inc_acc: assert property (p_inc_acc) else $error("inc late");
    property p_add_imm;
        take && opCode == 8'h24 |-> !opDone ##1 opDone;
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add len");
    property p_add_with_carry_reg;
        take && opCode[7:3] == 5'h07 |-> opDone;
    endproperty
    a_add_with_carry_reg: assert property (p_add_with_carry_reg) else $error("add_with_carry len");
    property p_subtract_with_borrow_dir;
        take && opCode == 8'h95 |-> !opDone ##1 opDone;
    endproperty
    a_subtract_with_borrow_dir: assert property (p_subtract_with_borrow_dir) else $error("subtract_with_borrow len");
    property p_inc_dir;
        take && opCode == 8'h05 |-> !opDone[*2] ##1 opDone ##1 resultValid;
    endproperty
    a_inc_dir: assert property (p_inc_dir) else $error("inc loc");
    property p_dec_reg;
        take && opCode[7:3] == 5'h03 |-> !opDone ##1 opDone;
    endproperty
    a_dec_reg: assert property (p_dec_reg) else $error("dec len");
    property p_mul;
        take && opCode == 8'hA4 |-> !opDone[*4] ##1 opDone;
    endproperty
    a_mul: assert property (p_mul) else $error("mul len");
    property p_div;
        take && opCode == 8'h84 |=> !opReady[*4] ##1 opReady;
    endproperty
    a_div: assert property (p_div) else $error("div busy");
    property p_da;
        take && opCode == 8'hD4 && !bWrEn |-> opDone ##1 $stable(bOut);
    endproperty
    a_da: assert property (p_da) else $error("da len");
    property p_parity;
        pswOut[0] == ^accOut;
    endproperty
    a_parity: assert property (p_parity) else $error("parity");
    c_div: cover property (take && opCode == 8'h84);
    c_res: cover property (resultValid);
    c_data_pointer_reg: cover property (dptrValid);
endmodule
bind mcu_arithmetic_logic_unit mcu_alu_checker u_chk (
    .sys_clk(sys_clk), .rst(rst), .opStart(opStart), .opCode(opCode),
    .operandIn(operandIn), .immIn(immIn), .dptrIn(dptrIn),
    .accWrEn(accWrEn), .bWrEn(bWrEn), .pswWrEn(pswWrEn),
    .sfrWrData(sfrWrData), .opReady(opReady), .opDone(opDone),
    .accOut(accOut), .bOut(bOut), .pswOut(pswOut),
    .resultOut(resultOut), .resultValid(resultValid),
    .dptrOut(dptrOut), .dptrValid(dptrValid));

/* sim/mcu_ctrl_model.sv */
// Control unit stand-in issuing ops and register writes
`timescale 1ns/1ps
module mcu_ctrl_model (
    input wire logic sys_clk,
    input wire logic opReady,
    input wire logic opDone,
    output logic opStart,
    output logic [7:0] opCode,
    output logic [7:0] operandIn,
    output logic [7:0] immIn,
    output logic [15:0] dptrIn,
    output logic accWrEn,
    output logic bWrEn,
    output logic pswWrEn,
    output logic [7:0] sfrWrData
);
    int cycles;
    initial begin
        {opStart, accWrEn, bWrEn, pswWrEn} = 4'h0;
        {opCode, operandIn, immIn, sfrWrData} = 32'h0000_0000;
        dptrIn = 16'h0000;
    end
    // Ends in the cycle after the commit edge
    task automatic runOp(input logic [7:0] code, input logic [7:0] opnd);
        logic done;
        @(posedge sys_clk);
        opStart <= 1'b1;
        opCode <= code;
        operandIn <= opnd;
        immIn <= {opnd[3:0], opnd[7:4]};
        dptrIn <= {8'h12, opnd};
        cycles = 0;
        done = 1'b0;
        while (!done && cycles < 8) begin
            @(negedge sys_clk);
            done = opDone;
            cycles++;
            @(posedge sys_clk);
            opStart <= 1'b0;
            operandIn <= ~opnd;
            immIn <= ~opnd;
        end
        @(negedge sys_clk);
    endtask
    task automatic sfrWr(input logic [2:0] sel, input logic [7:0] d);
        @(posedge sys_clk);
        {accWrEn, bWrEn, pswWrEn} <= sel;
        sfrWrData <= d;
        @(posedge sys_clk);
        {accWrEn, bWrEn, pswWrEn} <= 3'h0;
        sfrWrData <= ~d;
    endtask
endmodule

/* sim/mcu_arithmetic_logic_unit_test.sv */
// Self-checking bench for the ALU
`timescale 1ns/1ps
module mcu_arithmetic_logic_unit_test;
    logic sys_clk, rst, opStart, accWrEn, bWrEn, pswWrEn, opReady, opDone;
    logic resultValid, dptrValid;
    logic [7:0] opCode, operandIn, immIn, sfrWrData, accOut, bOut, pswOut;
    logic [7:0] resultOut;
    logic [15:0] dptrIn, dptrOut;
    int failCount = 0;
    int comparisons = 0;
    mcu_ctrl_model u_ctrl (.sys_clk(sys_clk), .opReady(opReady),
        .opDone(opDone), .opStart(opStart), .opCode(opCode),
        .operandIn(operandIn), .immIn(immIn), .dptrIn(dptrIn),
        .accWrEn(accWrEn), .bWrEn(bWrEn), .pswWrEn(pswWrEn),
        .sfrWrData(sfrWrData));
    mcu_arithmetic_logic_unit u_dut (.sys_clk(sys_clk), .rst(rst),
        .opStart(opStart), .opCode(opCode), .operandIn(operandIn),
        .immIn(immIn), .dptrIn(dptrIn), .accWrEn(accWrEn), .bWrEn(bWrEn),
        .pswWrEn(pswWrEn), .sfrWrData(sfrWrData), .opReady(opReady),
        .opDone(opDone), .accOut(accOut), .bOut(bOut), .pswOut(pswOut),
        .resultOut(resultOut), .resultValid(resultValid),
        .dptrOut(dptrOut), .dptrValid(dptrValid));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finishTest;
        $display("Comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic tCycles;
        logic [7:0] codes [24] = '{8'h28, 8'h25, 8'h26, 8'h24, 8'h38,
            8'h35, 8'h37, 8'h34, 8'h98, 8'h95, 8'h96, 8'h94, 8'h04, 8'hA3,
            8'h14, 8'h05, 8'h06, 8'h0F, 8'h15, 8'h17, 8'h18, 8'hA4, 8'h84,
            8'hD4};
        logic [15:0] lens [24] = '{1, 2, 2, 2, 1, 2, 2, 2, 1, 2, 2, 2, 1,
            1, 1, 3, 3, 2, 3, 3, 2, 5, 5, 1};
        for (int i = 0; i < 24; i++) begin
            u_ctrl.runOp(codes[i], 8'h11);
            check(16'(u_ctrl.cycles), lens[i]);
        end
    endtask
    task automatic tArith;
        u_ctrl.sfrWr(3'b100, 8'hF0);
        u_ctrl.sfrWr(3'b001, 8'h00);
        u_ctrl.runOp(8'h24, 8'h20);
        check({accOut, 6'h0, pswOut[7], pswOut[0]}, 16'h1003);
        u_ctrl.runOp(8'h34, 8'h01);
        check({accOut, 6'h0, pswOut[7], pswOut[0]}, 16'h1200);
        u_ctrl.runOp(8'h94, 8'h13);
        check({accOut, 6'h0, pswOut[7], pswOut[0]}, 16'hFF02);
    endtask
    task automatic tMulDiv;
        u_ctrl.sfrWr(3'b100, 8'h12);
        u_ctrl.sfrWr(3'b010, 8'h34);
        u_ctrl.runOp(8'hA4, 8'h00);
        check({bOut, accOut}, 16'h03A8);
        check({14'h0, pswOut[7], pswOut[2]}, 16'h0001);
        u_ctrl.sfrWr(3'b100, 8'hC8);
        u_ctrl.sfrWr(3'b010, 8'h0B);
        u_ctrl.runOp(8'h84, 8'h00);
        check({accOut, bOut}, 16'h1202);
    endtask
    task automatic tAccOnly;
        u_ctrl.sfrWr(3'b100, 8'h96);
        u_ctrl.sfrWr(3'b010, 8'h5A);
        u_ctrl.runOp(8'h23, 8'h00);
        check({accOut, bOut}, 16'h2D5A);
        u_ctrl.runOp(8'hC4, 8'h00);
        check({accOut, bOut}, 16'hD25A);
        u_ctrl.runOp(8'hF4, 8'h00);
        check({accOut, bOut}, 16'h2D5A);
        u_ctrl.runOp(8'hE4, 8'h00);
        check({accOut, bOut}, 16'h005A);
        u_ctrl.sfrWr(3'b100, 8'h38);
        u_ctrl.runOp(8'h24, 8'h49);
        u_ctrl.runOp(8'hD4, 8'h00);
        check({accOut, bOut}, 16'h875A);
        u_ctrl.runOp(8'h33, 8'h00);
        check({accOut, 7'h0, pswOut[7]}, 16'h0E01);
        u_ctrl.runOp(8'h13, 8'h00);
        u_ctrl.runOp(8'h03, 8'h00);
        check({accOut, 7'h0, pswOut[7]}, 16'hC300);
    endtask
    task automatic tLocs;
        u_ctrl.runOp(8'h05, 8'hFF);
        check({resultOut, 7'h0, resultValid}, 16'h0001);
        u_ctrl.runOp(8'h16, 8'h00);
        check({resultOut, 7'h0, resultValid}, 16'hFF01);
        u_ctrl.runOp(8'hA3, 8'hFF);
        check(dptrOut, 16'h1300);
        check({15'h0, dptrValid}, 16'h0001);
        u_ctrl.runOp(8'h53, 8'h5F);
        check({resultOut, 7'h0, resultValid}, 16'h5501);
        check(16'(u_ctrl.cycles), 16'h0004);
        u_ctrl.runOp(8'h64, 8'hFF);
        check({8'h00, accOut}, 16'h003C);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #125000;
        failCount++;
        finishTest();
    end
    initial begin
        rst = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check({accOut, pswOut}, 16'h0000);
        tCycles();
        tArith();
        tMulDiv();
        tAccOnly();
        tLocs();
        finishTest();
    end
endmodule
